// ---- rtl/hcr_regs.svh ----
`ifndef HCR_REGS_SVH
`define HCR_REGS_SVH

// ***********************************************************************
// Register offsets
// ***********************************************************************
`define HCR_ADDR_PORT_OFF_SP  8'h0a
`define HCR_ADDR_PORT_OFF_BP  8'h0b
`define HCR_ADDR_HC_CUR_SP    8'h0e
`define HCR_ADDR_HC_CUR_BP    8'h0f
`define HCR_ADDR_PWR_DELAY    8'h10

// ***********************************************************************
// Values and fields
// ***********************************************************************
`define HCR_RST_VAL           8'h00
`define HCR_ZERO_BYTE         8'h00
`define HCR_DEF_HC_CUR        8'h32
`define HCR_DEF_PWR_DELAY     8'h32
`define HCR_PORT_MASK         8'h06

// ***********************************************************************
// Timing
// ***********************************************************************
`define HCR_CLK_PERIOD_NS     50
`define HCR_OPER_DELAY_NS     500000
`define HCR_PWR_UNIT_NS       2000000

`endif

// ---- rtl/hcr_pkg.sv ----
package hcr_pkg;

   typedef enum logic [2:0] {
      HCR_ST_WAIT  = 3'b001,
      HCR_ST_FETCH = 3'b010,
      HCR_ST_RUN   = 3'b100
   } hcr_state_e;

   typedef enum logic [1:0] {
      HCR_CFG_EEPROM  = 2'b00,
      HCR_CFG_DEFAULT = 2'b01,
      HCR_CFG_STRAP   = 2'b10,
      HCR_CFG_NOSMB   = 2'b11
   } hcr_cfg_e;

endpackage

// ---- rtl/hcr_top.sv ----
`timescale 1ns/1ps
`include "hcr_regs.svh"

module hcr_top
   import hcr_pkg::*;
#(
   parameter int OPER_CYCLES = (`HCR_OPER_DELAY_NS + `HCR_CLK_PERIOD_NS - 1)
                               / `HCR_CLK_PERIOD_NS,
   parameter int UNIT_CYCLES = `HCR_PWR_UNIT_NS / `HCR_CLK_PERIOD_NS,
   parameter int CNT_W       = 16
) (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rstn,
   input  wire logic       usb_bus_reset,
   // Configuration select and power source
   input  wire logic [1:0] cfg_mode,
   input  wire logic       self_powered,
   // Configuration register port
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   output logic            reg_rvalid,
   // EEPROM loader
   output logic            eeprom_start,
   input  wire logic       eeprom_done,
   // Green LED strap pins
   input  wire logic [1:0] led_in,
   input  wire logic [1:0] led_on,
   output logic      [1:0] led_out,
   output logic      [1:0] led_oe,
   // Port power and transceivers
   input  wire logic       port_power_req,
   output logic            downstream_power_switch,
   output logic            port_power_good,
   output logic      [2:1] port_enable,
   output logic            phy_enable,
   output logic            osc_enable,
   output logic            pll_enable,
   output logic            operational
);

   // ********************************************************************
   // Helpers
   // ********************************************************************
   function automatic logic [7:0] hcr_port_bits(input logic [7:0] v);
      return v & `HCR_PORT_MASK;
   endfunction

   // ********************************************************************
   // State
   // ********************************************************************
   hcr_state_e       state;
   hcr_state_e       next_state;
   hcr_cfg_e         mode;
   logic [CNT_W-1:0] wait_cnt;
   logic [CNT_W-1:0] unit_cnt;
   logic [7:0]       units;
   logic [1:0]       strap;
   logic             strap_done;
   logic [7:0]       port_off_mask_self_powered;
   logic [7:0]       port_off_mask_bus_powered;
   logic [7:0]       hub_ctrl_current_self_powered;
   logic [7:0]       hub_ctrl_current_bus_powered;
   logic [7:0]       port_power_good_delay;

   // ********************************************************************
   // Decode
   // ********************************************************************
   wire logic       hit_off_sp = reg_addr == `HCR_ADDR_PORT_OFF_SP;
   wire logic       hit_off_bp = reg_addr == `HCR_ADDR_PORT_OFF_BP;
   wire logic       hit_cur_sp = reg_addr == `HCR_ADDR_HC_CUR_SP;
   wire logic       hit_cur_bp = reg_addr == `HCR_ADDR_HC_CUR_BP;
   wire logic       hit_delay  = reg_addr == `HCR_ADDR_PWR_DELAY;
   wire logic       hit_any    = hit_off_sp | hit_off_bp | hit_cur_sp |
                                 hit_cur_bp | hit_delay;
   wire logic       wr_ok      = reg_wr & (state != HCR_ST_WAIT);
   wire logic       wait_done  = (state == HCR_ST_WAIT) & osc_enable &
                                 (wait_cnt == CNT_W'(OPER_CYCLES - 1));
   wire logic       load_def   = wait_done & ((mode == HCR_CFG_DEFAULT) |
                                              (mode == HCR_CFG_STRAP));
   wire logic       load_strap = wait_done & (mode == HCR_CFG_STRAP);
   wire logic [7:0] strap_byte = hcr_port_bits({5'h00, strap, 1'b0});
   wire logic [7:0] off_sel    = self_powered ? port_off_mask_self_powered
                                              : port_off_mask_bus_powered;
   wire logic       unit_tick  = unit_cnt == CNT_W'(UNIT_CYCLES - 1);
   wire logic [7:0] rd_mux     =
      hit_off_sp ? port_off_mask_self_powered    :
      hit_off_bp ? port_off_mask_bus_powered     :
      hit_cur_sp ? hub_ctrl_current_self_powered :
      hit_cur_bp ? hub_ctrl_current_bus_powered  :
      hit_delay  ? port_power_good_delay         : `HCR_ZERO_BYTE;

   assign operational = state != HCR_ST_WAIT;
   assign port_enable = operational ? ~off_sel[2:1] : 2'h0;
   assign downstream_power_switch = (state == HCR_ST_RUN) &
                                    port_power_req;
   assign port_power_good = downstream_power_switch &
                            (units >= port_power_good_delay);

   // ********************************************************************
   // Sequencer
   // ********************************************************************
   always_comb begin
      next_state = state;
      unique case (state)
         HCR_ST_WAIT: begin
            if (wait_done) begin
               next_state = (mode == HCR_CFG_EEPROM) ? HCR_ST_FETCH
                                                     : HCR_ST_RUN;
            end
         end
         HCR_ST_FETCH: begin
            if (eeprom_done) begin
               next_state = HCR_ST_RUN;
            end
         end
         HCR_ST_RUN: begin
            next_state = HCR_ST_RUN;
         end
         default: begin
            next_state = HCR_ST_WAIT;
         end
      endcase
   end

   // Clocks restart at the first edge; the delay counts from that same edge
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state      <= HCR_ST_WAIT;
         wait_cnt   <= '0;
         osc_enable <= 1'b0;
         pll_enable <= 1'b0;
         phy_enable <= 1'b0;
      end else begin
         state      <= next_state;
         osc_enable <= 1'b1;
         pll_enable <= 1'b1;
         phy_enable <= 1'b1;
         if (state == HCR_ST_WAIT) begin
            wait_cnt <= wait_cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         eeprom_start <= 1'b0;
      end else begin
         eeprom_start <= wait_done & (mode == HCR_CFG_EEPROM);
      end
   end

   // ********************************************************************
   // Strap capture
   // ********************************************************************
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         strap      <= 2'h0;
         mode       <= HCR_CFG_EEPROM;
         strap_done <= 1'b0;
      end else if (!strap_done) begin
         strap      <= led_in;
         mode       <= hcr_cfg_e'(cfg_mode);
         strap_done <= 1'b1;
      end
   end

   // ********************************************************************
   // LED drive
   // ********************************************************************
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         led_out <= 2'h0;
         led_oe  <= 2'h0;
      end else begin
         led_out <= led_on ^ strap;
         led_oe  <= {2{strap_done}};
      end
   end

   // ********************************************************************
   // Configuration registers
   // ********************************************************************
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         port_off_mask_self_powered    <= `HCR_RST_VAL;
         port_off_mask_bus_powered     <= `HCR_RST_VAL;
         hub_ctrl_current_self_powered <= `HCR_RST_VAL;
         hub_ctrl_current_bus_powered  <= `HCR_RST_VAL;
         port_power_good_delay         <= `HCR_RST_VAL;
      end else if (load_def) begin
         hub_ctrl_current_self_powered <= `HCR_DEF_HC_CUR;
         hub_ctrl_current_bus_powered  <= `HCR_DEF_HC_CUR;
         port_power_good_delay         <= `HCR_DEF_PWR_DELAY;
         port_off_mask_self_powered    <= load_strap ? strap_byte
                                                     : `HCR_RST_VAL;
         port_off_mask_bus_powered     <= load_strap ? strap_byte
                                                     : `HCR_RST_VAL;
      end else if (wr_ok) begin
         // Undefined addresses fall through every test below
         if (hit_off_sp) begin
            port_off_mask_self_powered <= hcr_port_bits(reg_wdata);
         end
         if (hit_off_bp) begin
            port_off_mask_bus_powered <= hcr_port_bits(reg_wdata);
         end
         if (hit_cur_sp) begin
            hub_ctrl_current_self_powered <= reg_wdata;
         end
         if (hit_cur_bp) begin
            hub_ctrl_current_bus_powered <= reg_wdata;
         end
         if (hit_delay) begin
            port_power_good_delay <= reg_wdata;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata  <= `HCR_ZERO_BYTE;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rdata  <= reg_rd ? rd_mux : `HCR_ZERO_BYTE;
         reg_rvalid <= reg_rd;
      end
   end

   // ********************************************************************
   // Port power-good timer
   // ********************************************************************
   // Bus reset drops the timer only; configuration survives it
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         unit_cnt <= '0;
         units    <= 8'h00;
      end else if (!downstream_power_switch || usb_bus_reset) begin
         unit_cnt <= '0;
         units    <= 8'h00;
      end else if (unit_tick) begin
         unit_cnt <= '0;
         if (units != 8'hff) begin
            units <= units + 8'h01;
         end
      end else begin
         unit_cnt <= unit_cnt + 1'b1;
      end
   end

   // ********************************************************************
   // Checks
   // ********************************************************************
   logic [CNT_W-1:0] since_rst;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         since_rst <= '0;
      end else if (since_rst != '1) begin
         since_rst <= since_rst + 1'b1;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   sequence s_oper_rise;
      $rose(operational);
   endsequence

   sequence s_oper_in_mode(hcr_cfg_e m);
      s_oper_rise ##0 (mode == m);
   endsequence

   AST_PORTS_OFF_IN_WAIT: assert property (
      !operational |-> (port_enable == 2'h0) && !downstream_power_switch)
      else $error("ports or power switch active before operational");

   AST_PHY_BEFORE_OPER: assert property (
      !phy_enable |-> !operational && !pll_enable)
      else $error("operational while transceivers disabled");

   AST_OPER_DELAY: assert property (
      s_oper_rise |-> since_rst == CNT_W'(OPER_CYCLES))
      else $error("operational at wrong cycle after reset release");

   AST_EE_START: assert property (
      s_oper_in_mode(HCR_CFG_EEPROM) |-> eeprom_start ##1 !eeprom_start)
      else $error("eeprom read not started once operational");

   AST_NO_EE_START: assert property (
      (mode != HCR_CFG_EEPROM) |-> !eeprom_start)
      else $error("eeprom read started while not selected");

   AST_DEFAULT_LOAD: assert property (
      s_oper_in_mode(HCR_CFG_DEFAULT) |->
         (hub_ctrl_current_bus_powered == `HCR_DEF_HC_CUR) &&
         (hub_ctrl_current_self_powered == `HCR_DEF_HC_CUR) &&
         (port_off_mask_self_powered == `HCR_RST_VAL))
      else $error("internal defaults not loaded");

   AST_STRAP_LOAD: assert property (
      s_oper_in_mode(HCR_CFG_STRAP) |->
         (port_off_mask_bus_powered == strap_byte) &&
         (hub_ctrl_current_bus_powered == `HCR_DEF_HC_CUR))
      else $error("strap levels not applied");

   AST_UNMAPPED_READ: assert property (
      reg_rd && !hit_any |=> reg_rvalid && (reg_rdata == `HCR_ZERO_BYTE))
      else $error("undefined address read not zero");

   AST_UNMAPPED_WRITE: assert property (
      reg_wr && !hit_any && operational |=>
         $stable(hub_ctrl_current_bus_powered) &&
         $stable(port_power_good_delay) &&
         $stable(port_off_mask_bus_powered))
      else $error("undefined address write changed state");

   AST_STRAP_HOLD: assert property (
      strap_done |=> $stable(strap) && $stable(mode))
      else $error("strap levels changed after capture");

   AST_LED_POLARITY: assert property (
      strap_done ##1 strap_done |-> led_out == ($past(led_on) ^ strap))
      else $error("led polarity does not follow strap");

   AST_RESERVED_ZERO: assert property (
      ((port_off_mask_self_powered | port_off_mask_bus_powered) &
       ~`HCR_PORT_MASK) == `HCR_ZERO_BYTE)
      else $error("reserved port-off bits set");

   AST_PWR_GOOD_OFF: assert property (
      !downstream_power_switch || usb_bus_reset |=>
         (units == 8'h00) && (unit_cnt == '0))
      else $error("power-good timer not cleared");

endmodule

// ---- verif/hcr_eeprom_model.sv ----
`timescale 1ns/1ps

// ***********************************************************************
// Configuration EEPROM and LED strap resistors
// ***********************************************************************
module hcr_eeprom_model (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rstn,
   // Loader handshake
   input  wire logic       eeprom_start,
   input  wire logic [7:0] lag,
   output logic            eeprom_done,
   // LED pins with strap resistors
   input  wire logic [1:0] strap,
   input  wire logic [1:0] led_out,
   input  wire logic [1:0] led_oe,
   output logic      [1:0] led_in
);
   logic [7:0] cnt;
   logic       busy;

   // Device wins where it drives, the strap resistor elsewhere
   assign led_in = (led_oe & led_out) | (~led_oe & strap);

   // Only signals completion and writes nothing, so reserved bits stay 0
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         busy        <= 1'b0;
         cnt         <= 8'h00;
         eeprom_done <= 1'b0;
      end else begin
         eeprom_done <= 1'b0;
         if (eeprom_start) begin
            busy <= 1'b1;
            cnt  <= lag;
         end else if (busy && cnt == 8'h00) begin
            busy        <= 1'b0;
            eeprom_done <= 1'b1;
         end else if (busy) begin
            cnt <= cnt - 8'h01;
         end
      end
   end
endmodule

// ---- verif/hub_config_and_reset_control_test.sv ----
`timescale 1ns/1ps

module hub_config_and_reset_control_test;
   import hcr_pkg::*;
   localparam int OPER = 20;
   localparam int UNIT = 8;
   logic core_clk = 1'b0, rstn = 1'b0, usb_bus_reset = 1'b0;
   logic [1:0] cfg_mode = 2'b00, led_on = 2'b00, strap = 2'b00;
   logic self_powered = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, lag = 8'h03;
   logic port_power_req = 1'b0;
   logic [7:0] reg_rdata, rd;
   logic [1:0] led_out, led_oe, led_in, port_enable;
   logic reg_rvalid, eeprom_start, eeprom_done, downstream_power_switch;
   logic port_power_good, phy_enable, osc_enable, pll_enable, operational;
   int bad_count = 0, n_tests = 0, n_start = 0;

   always #25 core_clk = ~core_clk;
   always @(posedge core_clk) if (eeprom_start === 1'b1) n_start++;

   hcr_top #(.OPER_CYCLES(OPER), .UNIT_CYCLES(UNIT), .CNT_W(16)) dut (
      .core_clk(core_clk), .rstn(rstn), .usb_bus_reset(usb_bus_reset),
      .cfg_mode(cfg_mode), .self_powered(self_powered),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .eeprom_start(eeprom_start), .eeprom_done(eeprom_done),
      .led_in(led_in), .led_on(led_on), .led_out(led_out), .led_oe(led_oe),
      .port_power_req(port_power_req),
      .downstream_power_switch(downstream_power_switch),
      .port_power_good(port_power_good), .port_enable(port_enable),
      .phy_enable(phy_enable), .osc_enable(osc_enable),
      .pll_enable(pll_enable), .operational(operational));

   hcr_eeprom_model partner (
      .core_clk(core_clk), .rstn(rstn), .eeprom_start(eeprom_start),
      .lag(lag), .eeprom_done(eeprom_done), .strap(strap),
      .led_out(led_out), .led_oe(led_oe), .led_in(led_in));

   // ********************************************************************
   // Shared tasks
   // ********************************************************************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      if (bad_count == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [7:0] a);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      check({7'h00, reg_rvalid}, 8'h01);
      rd = reg_rdata;
   endtask

   // Reset with power requested; checks outputs in reset and the wake-up
   task automatic do_reset(input logic [1:0] mode, input logic [1:0] pins);
      @(posedge core_clk);
      rstn           <= 1'b0;
      cfg_mode       <= mode;
      strap          <= pins;
      port_power_req <= 1'b1;
      #1;
      check({6'h00, downstream_power_switch, operational}, 8'h00);
      check({6'h00, port_enable}, 8'h00);
      check({7'h00, phy_enable}, 8'h00);
      check({4'h0, osc_enable, pll_enable, led_oe}, 8'h00);
      check({7'h00, eeprom_start}, 8'h00);
      repeat (20) @(posedge core_clk); // 1 us low
      rstn           <= 1'b1;
      port_power_req <= 1'b0;
      n_start = 0;
      @(posedge core_clk);
      #1;
      check({5'h00, phy_enable, osc_enable, pll_enable}, 8'h07);
      repeat (OPER - 2) @(posedge core_clk);
      #1;
      check({7'h00, operational}, 8'h00);
      @(posedge core_clk);
      #1;
      check({7'h00, operational}, 8'h01);
   endtask

   // ********************************************************************
   // Scenarios
   // ********************************************************************
   task automatic test_default();
      do_reset(2'b01, 2'b11);
      reg_read(8'h0e); check(rd, 8'h32);
      reg_read(8'h0f); check(rd, 8'h32);
      reg_read(8'h10); check(rd, 8'h32);
      reg_read(8'h0a); check(rd, 8'h00);
      reg_read(8'h0b); check(rd, 8'h00);
      check(n_start[7:0], 8'h00);
   endtask

   task automatic test_regs();
      reg_write(8'h0f, 8'hab);
      reg_read(8'h0f); check(rd, 8'hab);
      reg_write(8'h20, 8'h5a);
      reg_read(8'h20); check(rd, 8'h00);
      reg_read(8'h0f); check(rd, 8'hab);
      reg_read(8'hff); check(rd, 8'h00);
      reg_write(8'h0b, 8'h06);
      reg_read(8'h0b); check(rd, 8'h06);
      check({6'h00, port_enable}, 8'h00);
   endtask

   task automatic test_power();
      reg_write(8'h10, 8'h02);
      reg_read(8'h10); check(rd, 8'h02);
      @(posedge core_clk);
      port_power_req <= 1'b1;
      #1;
      repeat (15) @(posedge core_clk);
      #1;
      check({6'h00, downstream_power_switch, port_power_good}, 8'h02);
      @(posedge core_clk);
      #1;
      check({7'h00, port_power_good}, 8'h01);
      @(posedge core_clk);
      usb_bus_reset <= 1'b1;
      repeat (2) @(posedge core_clk);
      usb_bus_reset <= 1'b0;
      #1;
      check({6'h00, downstream_power_switch, port_power_good}, 8'h02);
      reg_read(8'h10); check(rd, 8'h02);
   endtask

   task automatic test_strap();
      do_reset(2'b10, 2'b10);
      reg_read(8'h0a); check(rd, 8'h04);
      reg_read(8'h0b); check(rd, 8'h04);
      reg_read(8'h0e); check(rd, 8'h32);
      reg_read(8'h0f); check(rd, 8'h32);
      @(posedge core_clk);
      self_powered <= 1'b1;
      led_on       <= 2'b11;
      strap        <= 2'b01;
      repeat (2) @(posedge core_clk);
      #1;
      check({6'h00, port_enable}, 8'h01);
      check({4'h0, led_out, led_oe}, 8'h07);
      @(posedge core_clk);
      led_on       <= 2'b00;
      self_powered <= 1'b0;
      reg_read(8'h0a); check(rd, 8'h04);
      check({6'h00, led_out}, 8'h02);
   endtask

   task automatic test_eeprom();
      int k;
      do_reset(2'b00, 2'b00);
      check({6'h00, eeprom_start, downstream_power_switch}, 8'h02);
      @(posedge core_clk);
      port_power_req <= 1'b1;
      reg_read(8'h0f); check(rd, 8'h00);
      for (k = 0; k < 20 && eeprom_done !== 1'b1; k++) begin
         @(posedge core_clk);
         #1;
      end
      check({7'h00, eeprom_done}, 8'h01);
      @(posedge core_clk);
      #1;
      check({7'h00, downstream_power_switch}, 8'h01);
      check(n_start[7:0], 8'h01);
   endtask

   task automatic test_nosmb();
      do_reset(2'b11, 2'b11);
      repeat (10) @(posedge core_clk);
      check(n_start[7:0], 8'h00);
      reg_read(8'h10); check(rd, 8'h00);
   endtask

   // ********************************************************************
   // Main sequence and watchdog
   // ********************************************************************
   initial begin
      repeat (5) @(posedge core_clk);
      test_default();
      test_regs();
      test_power();
      test_strap();
      test_eeprom();
      test_nosmb();
      report_and_stop();
   end

   initial begin
      #(4000 * 50);
      bad_count++;
      report_and_stop();
   end
endmodule
